// ==== ufc_pkg.sv ====
/*
 * ufc_pkg: constants and carrier types for the flow-controlled serial port.
 * assumes a 200 MHz system clock; depends on no other file.
 */
package ufc_pkg;
    localparam int unsigned UFC_CLK_HZ = 200_000_000;
    localparam int unsigned UFC_MAX_BAUD = 1_000_000;
    localparam int unsigned UFC_DEF_BAUD = 115_200;
    // least divider at the top rate, rounded down so the bit is never too long
    localparam int unsigned UFC_MIN_DIV = UFC_CLK_HZ / UFC_MAX_BAUD;
    localparam int unsigned UFC_DEF_DIV_I = UFC_CLK_HZ / UFC_DEF_BAUD;
    localparam logic [15:0] UFC_DEF_DIV = UFC_DEF_DIV_I[15:0];
    localparam logic [15:0] UFC_MIN_DIV_W = UFC_MIN_DIV[15:0];
    localparam int unsigned UFC_DATA_BITS = 8;
    localparam logic [3:0] UFC_LAST_BIT = 4'h7;
    localparam int unsigned UFC_RX_DEPTH = 16;
    localparam logic [4:0] UFC_RX_DEPTH_W = 5'h10;
    // slack left when handshake drops: characters a host may still have in flight
    localparam logic [4:0] UFC_RTS_SLACK = 5'h4;
    localparam logic UFC_LINE_IDLE = 1'b1;
    localparam logic UFC_START_LVL = 1'b0;
    localparam logic UFC_STOP_LVL = 1'b1;
    localparam logic UFC_HS_ASSERT = 1'b0;
    localparam logic UFC_HS_DEASSERT = 1'b1;

    typedef enum logic [1:0] {
        UFC_ST_IDLE = 2'b00,
        UFC_ST_START = 2'b01,
        UFC_ST_DATA = 2'b10,
        UFC_ST_STOP = 2'b11
    } ufc_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ufc_byte_t;

    typedef struct packed {
        logic frame_err;
        logic overrun;
    } ufc_err_t;
endpackage

// ==== ufc_uart.sv ====
/*
 * ufc_uart: full-duplex 8N1 serial port with active-low two-way flow control
 * and a small receive buffer that drives the request-to-send line.
 * assumes all inputs synchronous to i_clk; pad pulls and levels sit outside.
 */
// Summary of operation
// RULE_01 - full duplex async link with hardware flow control, up to 1 Mbps
// RULE_02 - device drives request-to-send, samples host-driven clear-to-send
// RULE_03 - both handshake lines active low: low asserted, high deasserted
// RULE_04 - idle data lines rest high
// RULE_05 - transmit pin is an output defaulting high
// RULE_06 - receive pin is an input with pull-up, open line reads idle
// RULE_07 - request-to-send output defaults low, ready to receive
// RULE_08 - clear-to-send input with pull-down, open line reads asserted
// RULE_09 - host sends into device receive line, listens on device transmit
// RULE_10 - host should stop sending once request-to-send deasserts
// RULE_11 - framing and handshake interoperate with standard UART controllers
// RULE_12 - request-to-send drops before buffer fills, room for in-flight characters
// RULE_13 - frame is low start, eight data bits lsb first, high stop
`timescale 1ns/100ps
module ufc_uart
    import ufc_pkg::*;
(
    // clock and control
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [15:0] i_baud_div,
    // serial pins
    output logic o_port_pin_six,
    input wire logic i_port_pin_eight,
    output logic o_port_pin_five,
    input wire logic i_port_pin_seven,
    // transmit stream
    input wire ufc_byte_t i_tx,
    output logic o_tx_ready,
    // receive stream and transmit busy
    output ufc_byte_t o_rx,
    input wire logic i_rx_ready,
    output ufc_err_t o_rx_err,
    output logic o_tx_busy
);
    // divider never below the top-rate value
    wire logic div_small = i_baud_div < UFC_MIN_DIV_W;
    wire logic [15:0] div = div_small ? UFC_MIN_DIV_W : i_baud_div; // RULE_01
    wire logic [15:0] half_div = {1'b0, div[15:1]};
    wire logic cts_on = (i_port_pin_seven == UFC_HS_ASSERT); // RULE_02 RULE_03 RULE_08

    // transmitter
    ufc_state_t tx_st_reg, tx_st_next;
    logic [15:0] tx_cnt_reg;
    logic [3:0] tx_bit_reg;
    logic [7:0] tx_sh_reg;
    logic tx_line_reg;
    wire logic tx_tick = (tx_cnt_reg == div - 16'h1);
    wire logic tx_take = (tx_st_reg == UFC_ST_IDLE) && i_tx.valid && cts_on; // RULE_02
    assign o_tx_ready = (tx_st_reg == UFC_ST_IDLE) && cts_on;
    assign o_tx_busy = (tx_st_reg != UFC_ST_IDLE);

    always_comb begin
        tx_st_next = tx_st_reg;
        case (tx_st_reg)
            UFC_ST_IDLE: if (tx_take) tx_st_next = UFC_ST_START;
            UFC_ST_START: if (tx_tick) tx_st_next = UFC_ST_DATA;
            UFC_ST_DATA: if (tx_tick && tx_bit_reg == UFC_LAST_BIT) tx_st_next = UFC_ST_STOP;
            UFC_ST_STOP: if (tx_tick) tx_st_next = UFC_ST_IDLE;
            default: tx_st_next = UFC_ST_IDLE;
        endcase
    end

    // line value for next cycle: start, data lsb first, stop, idle high
    // on a shift edge the register still holds the old bit, so look one ahead
    wire logic tx_shift = tx_tick && (tx_st_reg == UFC_ST_DATA);
    wire logic tx_data_bit = tx_shift ? tx_sh_reg[1] : tx_sh_reg[0];
    logic tx_line_next;
    always_comb begin
        case (tx_st_next)
            UFC_ST_START: tx_line_next = UFC_START_LVL; // RULE_13
            UFC_ST_DATA: tx_line_next = tx_data_bit; // RULE_13
            UFC_ST_STOP: tx_line_next = UFC_STOP_LVL; // RULE_13
            default: tx_line_next = UFC_LINE_IDLE; // RULE_04
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            tx_st_reg <= UFC_ST_IDLE;
            tx_cnt_reg <= 16'h0;
            tx_bit_reg <= 4'h0;
            tx_sh_reg <= 8'h0;
            tx_line_reg <= UFC_LINE_IDLE; // RULE_05
        end else if (i_ce) begin
            tx_st_reg <= tx_st_next;
            tx_line_reg <= tx_line_next;
            tx_cnt_reg <= (tx_st_reg == UFC_ST_IDLE || tx_tick) ? 16'h0 : tx_cnt_reg + 16'h1;
            if (tx_take) begin
                tx_sh_reg <= i_tx.data;
                tx_bit_reg <= 4'h0;
            end else if (tx_tick && tx_st_reg == UFC_ST_DATA) begin
                tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
                tx_bit_reg <= tx_bit_reg + 4'h1;
            end
        end
    end
    assign o_port_pin_six = tx_line_reg; // RULE_05 RULE_09

    // receiver: samples at mid-bit
    ufc_state_t rx_st_reg, rx_st_next;
    logic [15:0] rx_cnt_reg;
    logic [3:0] rx_bit_reg;
    logic [7:0] rx_sh_reg;
    wire logic rx_line = i_port_pin_eight; // RULE_06 RULE_09
    wire logic rx_half = (rx_cnt_reg == half_div);
    wire logic rx_tick = (rx_cnt_reg == div - 16'h1);
    wire logic rx_done = (rx_st_reg == UFC_ST_STOP) && rx_tick;
    wire logic rx_stop_ok = (rx_line == UFC_STOP_LVL);

    always_comb begin
        rx_st_next = rx_st_reg;
        case (rx_st_reg)
            UFC_ST_IDLE: if (rx_line == UFC_START_LVL) rx_st_next = UFC_ST_START; // RULE_13
            UFC_ST_START: if (rx_half) begin
                rx_st_next = (rx_line == UFC_START_LVL) ? UFC_ST_DATA : UFC_ST_IDLE;
            end
            UFC_ST_DATA: if (rx_tick && rx_bit_reg == UFC_LAST_BIT) rx_st_next = UFC_ST_STOP;
            UFC_ST_STOP: if (rx_tick) rx_st_next = UFC_ST_IDLE;
            default: rx_st_next = UFC_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rx_st_reg <= UFC_ST_IDLE;
            rx_cnt_reg <= 16'h0;
            rx_bit_reg <= 4'h0;
            rx_sh_reg <= 8'h0;
        end else if (i_ce) begin
            rx_st_reg <= rx_st_next;
            if (rx_st_reg == UFC_ST_IDLE || (rx_st_reg == UFC_ST_START && rx_half) || rx_tick)
                rx_cnt_reg <= 16'h0;
            else
                rx_cnt_reg <= rx_cnt_reg + 16'h1;
            if (rx_st_reg == UFC_ST_START)
                rx_bit_reg <= 4'h0;
            else if (rx_tick && rx_st_reg == UFC_ST_DATA) begin
                rx_sh_reg <= {rx_line, rx_sh_reg[7:1]}; // RULE_13
                rx_bit_reg <= rx_bit_reg + 4'h1;
            end
        end
    end

    // receive buffer; its fill level steers request-to-send
    logic [7:0] buf_mem [UFC_RX_DEPTH];
    logic [3:0] wr_ptr_reg, rd_ptr_reg;
    logic [4:0] cnt_reg;
    logic rts_n_reg;
    ufc_err_t err_reg;
    wire logic buf_full = (cnt_reg == UFC_RX_DEPTH_W);
    wire logic buf_empty = (cnt_reg == 5'h0);
    wire logic push = rx_done && rx_stop_ok && !buf_full;
    wire logic pop = !buf_empty && i_rx_ready;
    // headroom kept for characters a host already had in flight
    wire logic rts_drop = (cnt_reg >= UFC_RX_DEPTH_W - UFC_RTS_SLACK); // RULE_12
    assign o_rx.valid = !buf_empty;
    assign o_rx.data = buf_mem[rd_ptr_reg];
    assign o_rx_err = err_reg;

    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            buf_mem[wr_ptr_reg] <= rx_sh_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            cnt_reg <= 5'h0;
            rts_n_reg <= UFC_HS_ASSERT; // RULE_07
            err_reg <= '0;
        end else if (i_ce) begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 4'h1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 4'h1;
            cnt_reg <= cnt_reg + {4'h0, push} - {4'h0, pop};
            rts_n_reg <= rts_drop ? UFC_HS_DEASSERT : UFC_HS_ASSERT; // RULE_02 RULE_03 RULE_12
            // sticky flags, one-way: host misbehaviour stays visible
            if (rx_done && !rx_stop_ok) err_reg.frame_err <= 1'b1; // RULE_11
            if (rx_done && rx_stop_ok && buf_full) err_reg.overrun <= 1'b1; // RULE_10
        end
    end
    assign o_port_pin_five = rts_n_reg; // RULE_07

    AST_TX_IDLE_HIGH: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_04
        (tx_st_reg == UFC_ST_IDLE && $past(tx_st_reg) == UFC_ST_IDLE) |-> o_port_pin_six)
        else $error("tx line not high while idle");
    AST_TX_START_LOW: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_13
        (tx_take && i_ce) |=> !o_port_pin_six)
        else $error("start bit not low");
    AST_TX_NEEDS_CTS: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_02
        (tx_st_reg == UFC_ST_IDLE && $past(tx_st_reg) == UFC_ST_IDLE && i_port_pin_seven
         && i_ce) |=> tx_st_reg == UFC_ST_IDLE)
        else $error("sent while clear-to-send deasserted");
    AST_RTS_HEADROOM: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_12
        (cnt_reg >= UFC_RX_DEPTH_W - UFC_RTS_SLACK && i_ce) |=> o_port_pin_five)
        else $error("request-to-send still asserted near full");
    AST_RTS_READY: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_07
        (!$past(i_rstn) || (cnt_reg == 5'h0 && $past(cnt_reg) == 5'h0)) |-> !o_port_pin_five)
        else $error("request-to-send not low when empty");
    AST_DIV_FLOOR: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_01
        div >= UFC_MIN_DIV_W)
        else $error("bit period below top rate");
    AST_STOP_HIGH: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_13
        (tx_st_reg == UFC_ST_STOP) |-> o_port_pin_six || $past(tx_st_reg) != UFC_ST_STOP)
        else $error("stop bit not high");
    AST_NO_OVERFILL: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_12
        cnt_reg <= UFC_RX_DEPTH_W)
        else $error("receive buffer overfilled");
    AST_TX_BIT_ALIGN: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_13
        (tx_st_reg == UFC_ST_DATA && tx_cnt_reg == 16'h0) |-> o_port_pin_six == tx_sh_reg[0])
        else $error("data bit out of step with its period");
    AST_FRAME_FLAG: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_11
        (rx_done && !rx_stop_ok && i_ce) |=> o_rx_err.frame_err)
        else $error("bad stop bit not flagged");
    AST_OVERRUN_FLAG: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_12
        (rx_done && rx_stop_ok && buf_full && i_ce) |=> o_rx_err.overrun)
        else $error("character lost to a full buffer not flagged");
endmodule

// ==== ufc_host.sv ====
/*
 * ufc_host: behavioural host serial port facing the flow-controlled port.
 * assumes 8N1 framing at DIV clocks per bit, synchronous to i_clk.
 */
`timescale 1ns/100ps
module ufc_host
    import ufc_pkg::*;
#(
    parameter int DIV = 200
) (
    // clock and pins
    input wire logic i_clk,
    input wire logic i_line_in,
    input wire logic i_rts_n,
    input wire logic i_hold,
    output logic o_line_out,
    output logic o_cts_n
);
    logic [8:0] got[$];
    logic [8:0] sh;
    assign o_cts_n = i_hold ? UFC_HS_DEASSERT : UFC_HS_ASSERT;
    initial o_line_out = UFC_LINE_IDLE;
    // obey low lets a test overrun the buffer on purpose
    task automatic send(input logic [7:0] d, input bit obey, input logic stp);
        logic [9:0] f;
        f = {stp, d, UFC_START_LVL};
        while (obey && i_rts_n !== UFC_HS_ASSERT) @(posedge i_clk);
        @(posedge i_clk);
        for (int i = 0; i < 10; i++) begin
            #1 o_line_out = f[i];
            repeat (DIV) @(posedge i_clk);
        end
        #1 o_line_out = UFC_LINE_IDLE;
    endtask
    // sample each bit at its middle
    always begin
        @(negedge i_line_in);
        repeat (DIV / 2) @(posedge i_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (DIV) @(posedge i_clk);
            sh[i] = i_line_in;
        end
        got.push_back(sh);
    end
endmodule

// ==== uart_with_flow_control_tb.sv ====
/*
 * uart_with_flow_control_tb: self-checking bench for ufc_uart with a host model.
 * assumes ufc_pkg, ufc_uart and ufc_host are compiled first.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: value mismatch", $time); end end
module uart_with_flow_control_tb;
    import ufc_pkg::*;
    logic clk = 0, rstn = 0, hold = 0, rx_ready = 0, pin_six, pin_five, rx_line, cts_n;
    logic tx_ready, busy, ce = 1;
    logic [15:0] div;
    ufc_byte_t tx = '0, rx;
    ufc_err_t err;
    logic [7:0] q[$];
    logic [7:0] d;
    int n_fail = 0, checks = 0, cyc = 0;
    initial forever #2.5 clk = ~clk;
    ufc_uart u_dut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_baud_div(div),
        .o_port_pin_six(pin_six), .i_port_pin_eight(rx_line), .o_port_pin_five(pin_five),
        .i_port_pin_seven(cts_n), .i_tx(tx), .o_tx_ready(tx_ready), .o_rx(rx),
        .i_rx_ready(rx_ready), .o_rx_err(err), .o_tx_busy(busy));
    ufc_host #(.DIV(200)) u_host (.i_clk(clk), .i_line_in(pin_six), .i_rts_n(pin_five),
        .i_hold(hold), .o_line_out(rx_line), .o_cts_n(cts_n));
    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // host sees the stop bit above the data byte
    function automatic logic [8:0] exp_frame(input logic [7:0] v);
        return {UFC_STOP_LVL, v};
    endfunction
    task automatic tx_byte(input logic [7:0] v);
        @(posedge clk);
        #1 tx = {1'b1, v};
        while (tx_ready !== 1'b1) begin @(posedge clk); #1; end
        @(posedge clk);
        #1 tx.valid = 1'b0;
        `CHK(pin_six, UFC_START_LVL)
        `CHK(busy, 1'b1)
    endtask
    task automatic pop_chk();
        @(posedge clk);
        #1;
        while (rx.valid !== 1'b1) begin @(posedge clk); #1; end
        `CHK(rx.data, q.pop_front())
        rx_ready = 1'b1;
        @(posedge clk);
        #1 rx_ready = 1'b0;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin n_fail++; close_out(); end
    end
    initial begin
        void'($urandom(15409));
        // any divider up to the floor runs at the top rate
        div = 16'($urandom_range(200, 0));
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        `CHK(pin_six, UFC_LINE_IDLE)
        `CHK(pin_five, UFC_HS_ASSERT)
        `CHK({rx.valid, err}, 3'h0)
        `CHK(tx_ready, 1'b1)
        hold = 1'b1;
        tx = {1'b1, 8'h5A};
        @(posedge clk);
        #1 `CHK(tx_ready, 1'b0)
        `CHK(busy, 1'b0)
        // frozen by the clock enable: a pending byte must not start
        hold = 1'b0;
        ce = 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK(busy, 1'b0)
        `CHK(pin_six, UFC_LINE_IDLE)
        tx.valid = 1'b0;
        ce = 1'b1;
        for (int i = 0; i < 6; i++) begin
            d = (i < 3) ? 8'(8'hA5 >> (4 * i)) : 8'($urandom());
            q.push_back(d);
            tx_byte(d);
        end
        while (u_host.got.size() < 6) @(posedge clk);
        for (int i = 0; i < 6; i++) `CHK(u_host.got[i], exp_frame(q.pop_front()))
        for (int i = 0; i < 17; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom());
            if (i < 16) q.push_back(d);
            u_host.send(d, i < 12, UFC_STOP_LVL);
            if (i == 11) `CHK(pin_five, UFC_HS_DEASSERT)
        end
        `CHK(err.overrun, 1'b1)
        for (int i = 0; i < 16; i++) begin
            pop_chk();
            if (i == 4) begin @(posedge clk); #1 `CHK(pin_five, UFC_HS_ASSERT) end
        end
        u_host.send(8'h3C, 1'b1, UFC_START_LVL);
        `CHK(err.frame_err, 1'b1)
        `CHK(rx.valid, 1'b0)
        // reset again mid-run: sticky flags clear and a fresh byte still lands
        rstn = 1'b0;
        @(posedge clk);
        #1 rstn = 1'b1;
        `CHK({pin_five, err}, 3'h0)
        q.push_back(8'hC3);
        u_host.send(8'hC3, 1'b1, UFC_STOP_LVL);
        pop_chk();
        close_out();
    end
endmodule
